// ### bench/arith_bit_checker.sv
// Purpose: timing and result assertions on the arithmetic and bit datapath ports
// Assumes: ce_in held high while a request is in flight
// Notes:   request fields count only at the take edge, so the carry check latches the bit
`timescale 1ns/10ps
module arith_bit_checker
   import arith_bit_pkg::*;
#(
   parameter logic [CNT_W-1:0] SKIP_CYCLES = SKIP_CYCLES_DEFAULT
) (
   input  wire logic                clk_in,
   input  wire logic                sys_rst_in,
   input  wire logic                ce_in,
   input  wire logic                start_in,
   input  request_type              req_in,
   input  wire logic [NIBBLE_W-1:0] mem_rdata_in,
   input  wire logic                ready_out,
   input  wire logic                done_out,
   input  wire logic                skip_out,
   input  wire logic                carry_out,
   input  wire logic [PAIR_W-1:0]   ea_out,
   input  mem_write_type            mem_write_out
);
   logic             take;
   logic [CNT_W-1:0] skip_cnt_reg;
   logic             bit_reg;

   assign take = start_in && ready_out && ce_in;

   // counts skip cycles so the skip length can be checked for any parameter value
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) skip_cnt_reg <= '0;
      else if (!skip_out) skip_cnt_reg <= '0;
      else if (ce_in) skip_cnt_reg <= skip_cnt_reg + 4'h1;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) bit_reg <= 1'b0;
      else if (take) bit_reg <= mem_rdata_in[req_in.bit_sel];
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_take_drops_ready: assert property (take |=> !ready_out)
      else $error("ready stayed high after a take");
   a_done_while_busy: assert property (done_out |-> !ready_out)
      else $error("done while idle");
   a_done_then_idle: assert property (done_out && ce_in |=> ready_out)
      else $error("not idle after done");
   a_short_add_one: assert property (take && req_in.op == OP_ADC_A_MEM |=> done_out && !skip_out)
      else $error("nibble add not one cycle");
   a_pair_arith_two: assert property (take && req_in.op inside {OP_ADC_EA_RR, OP_SBC_EA_RR}
      |=> !done_out ##1 (done_out && !skip_out))
      else $error("pair add or subtract not two cycles");
   a_carry_test_skip: assert property (take && req_in.op == OP_TEST_BIT_SKIP_SET_C && carry_out
      |=> !done_out ##1 skip_out)
      else $error("set carry did not skip");
   a_clear_carry_on: assert property (take && req_in.op == OP_TEST_BIT_SKIP_SET_C && !carry_out
      |=> done_out && !skip_out)
      else $error("clear carry skipped");
   a_skip_length: assert property (skip_out && done_out |-> skip_cnt_reg == SKIP_CYCLES - 4'h1)
      else $error("skip length wrong");
   a_write_one_pulse: assert property (mem_write_out.wr |=> !mem_write_out.wr)
      else $error("memory write longer than one cycle");
   a_zero_bit_kept: assert property (take && req_in.op == OP_TEST_CLEAR_BIT_SKIP_MEM
      && !mem_rdata_in[req_in.bit_sel] |=> !mem_write_out.wr [*3])
      else $error("clear bit written although bit was zero");
   a_bit_to_carry: assert property (take && req_in.op == OP_LDB_C_MEM && !req_in.direct_form
      |=> ##1 carry_out == bit_reg)
      else $error("carry does not match memory bit");

   c_skip_done: cover property (skip_out && done_out);
   c_mem_write: cover property (mem_write_out.wr);
   c_imm_add: cover property (take && req_in.op == OP_ADS_A_IMM);
endmodule // arith_bit_checker

bind arith_bit_datapath arith_bit_checker #(.SKIP_CYCLES(SKIP_CYCLES)) i_arith_bit_checker (
   .clk_in, .sys_rst_in, .ce_in, .start_in, .req_in, .mem_rdata_in, .ready_out, .done_out,
   .skip_out, .carry_out, .ea_out, .mem_write_out);

// ### bench/tb.sv
// Purpose: directed self-checking bench for the arithmetic and bit datapath
// Assumes: pairs start at zero; each request runs to its end before the next
// Notes:   skip length set to 2 so an off-by-one in the skip count shows up
`timescale 1ns/10ps
module tb import arith_bit_pkg::*;;
   localparam logic [CNT_W-1:0] SK = 4'h2;
   localparam logic [CNT_W-1:0] S1 = 4'h1 + SK;
   localparam logic [CNT_W-1:0] S2 = 4'h2 + SK;
   logic                clk_in = 1'b0;
   logic                sys_rst_in;
   logic                ce_in;
   logic                start_in;
   request_type         req_in;
   logic [NIBBLE_W-1:0] mem_rdata_in;
   logic                ready_out;
   logic                done_out;
   logic                skip_out;
   logic                carry_out;
   logic [PAIR_W-1:0]   ea_out;
   mem_write_type       mem_write_out;
   int                  fail_count = 0;
   int                  cmp_count = 0;

   always #2.5 clk_in = ~clk_in;

   arith_bit_datapath #(.SKIP_CYCLES(SK)) i_arith_bit_datapath (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .start_in(start_in),
      .req_in(req_in), .mem_rdata_in(mem_rdata_in), .ready_out(ready_out),
      .done_out(done_out), .skip_out(skip_out), .carry_out(carry_out), .ea_out(ea_out),
      .mem_write_out(mem_write_out));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one request, then cycles, skip, accumulator pair, carry and memory write are judged
   task automatic run(input op_type op, input logic [3:0] m, input logic [3:0] cyc,
         input logic sk, input logic [7:0] ea, input logic c, input logic [1:0] bs = 2'h0,
         input logic wr = 1'b0, input logic [3:0] wd = 4'h0, input logic df = 1'b0,
         input logic [7:0] imm = 8'h00, input logic [2:0] ri = 3'h0, input logic [1:0] pi = 2'h1);
      int            n;
      logic          sk_seen;
      mem_write_type w;
      sk_seen = 1'b0;
      w = '0;
      @(posedge clk_in);
      start_in     <= 1'b1;
      req_in       <= '{op, imm[3:0], imm[7:4], ri, pi, bs, df};
      mem_rdata_in <= m;
      @(posedge clk_in);
      start_in <= 1'b0;
      for (n = 1; n < 20; n++) begin
         #1;
         sk_seen |= skip_out;
         if (mem_write_out.wr === 1'b1) w = mem_write_out;
         if (done_out === 1'b1) break;
         @(posedge clk_in);
      end
      if (n == 20) begin
         fail_count++;
         summarize();
      end
      @(posedge clk_in);
      #1;
      if (mem_write_out.wr === 1'b1) w = mem_write_out;
      check(8'(n), {4'h0, cyc});
      check({7'h0, sk_seen}, {7'h0, sk});
      check({7'h0, carry_out}, {7'h0, c});
      check({3'h0, w}, {3'h0, wr, wd});
      check({7'h0, ready_out}, 8'h01);
      // accumulator pair shows through a read flop, one clock after the write
      @(posedge clk_in);
      #1;
      check(ea_out, ea);
   endtask

   // a request offered while the clock enable is low must not be taken
   task automatic freeze();
      @(posedge clk_in);
      ce_in    <= 1'b0;
      start_in <= 1'b1;
      req_in   <= '{OP_TEST_BIT_SKIP_SET_C, 4'h0, 4'h0, 3'h0, 2'h0, 2'h0, 1'b0};
      repeat (2) @(posedge clk_in);
      start_in <= 1'b0;
      ce_in    <= 1'b1;
      #1;
      check({6'h0, ready_out, done_out}, 8'h02);
   endtask

   task automatic arith_nibble();
      run(OP_ADS_A_IMM, 4'h0, 4'h1, 1'b0, 8'h0F, 1'b0, 2'h0, 1'b0, 4'h0, 1'b0, 8'h0F);
      run(OP_ADS_A_IMM, 4'h0, S1, 1'b1, 8'h00, 1'b0, 2'h0, 1'b0, 4'h0, 1'b0, 8'h01);
      run(OP_ADS_A_MEM, 4'h3, 4'h1, 1'b0, 8'h03, 1'b0);
      run(OP_SBC_A_MEM, 4'h4, 4'h1, 1'b0, 8'h0F, 1'b1);
      run(OP_ADC_A_MEM, 4'h0, 4'h1, 1'b0, 8'h00, 1'b1);
      run(OP_SBS_A_MEM, 4'h1, S1, 1'b1, 8'h0F, 1'b1);
      run(OP_TEST_BIT_SKIP_SET_C, 4'h0, S1, 1'b1, 8'h0F, 1'b1);
   endtask

   task automatic arith_pair();
      run(OP_ADC_EA_RR, 4'h0, 4'h2, 1'b0, 8'h10, 1'b0);
      run(OP_DECREMENT_SKIP_BORROW_RR, 4'h0, S2, 1'b1, 8'h10, 1'b0);
      run(OP_ADS_EA_RR, 4'h0, S2, 1'b1, 8'h0F, 1'b0);
      run(OP_SBC_EA_RR, 4'h0, 4'h2, 1'b0, 8'h10, 1'b1);
      run(OP_SBS_EA_RR, 4'h0, S2, 1'b1, 8'h11, 1'b1);
      run(OP_ADS_EA_IMM, 4'h0, 4'h2, 1'b0, 8'hFF, 1'b1, 2'h0, 1'b0, 4'h0, 1'b0, 8'hEE);
      run(OP_INCREMENT_SKIP_CARRY_R, 4'h0, S1, 1'b1, 8'hF0, 1'b1, 2'h0, 1'b0, 4'h0, 1'b0, 8'h00, 3'h0);
      run(OP_DECREMENT_SKIP_BORROW_R, 4'h0, 4'h1, 1'b0, 8'hE0, 1'b1, 2'h0, 1'b0, 4'h0, 1'b0, 8'h00, 3'h1);
      run(OP_INCREMENT_SKIP_CARRY_MEM_DA, 4'hF, S2, 1'b1, 8'hE0, 1'b1, 2'h0, 1'b1, 4'h0, 1'b1);
      run(OP_INCREMENT_SKIP_CARRY_RR, 4'h0, S1, 1'b1, 8'hE0, 1'b1);
      run(OP_ADS_RR_EA, 4'h0, 4'h2, 1'b0, 8'hE0, 1'b1);
   endtask

   task automatic bit_ops();
      run(OP_TEST_BIT_SKIP_SET_MEM, 4'h4, S2, 1'b1, 8'hE0, 1'b1, 2'h2, 1'b0, 4'h0, 1'b1);
      run(OP_TEST_BIT_SKIP_ZERO_MEM, 4'hE, S1, 1'b1, 8'hE0, 1'b1);
      run(OP_TEST_BIT_SKIP_ZERO_MEM, 4'h1, 4'h1, 1'b0, 8'hE0, 1'b1);
      run(OP_TEST_CLEAR_BIT_SKIP_MEM, 4'h8, S1, 1'b1, 8'hE0, 1'b1, 2'h3, 1'b1, 4'h0);
      run(OP_TEST_CLEAR_BIT_SKIP_MEM, 4'h7, 4'h1, 1'b0, 8'hE0, 1'b1, 2'h3);
      run(OP_BITS_MEM, 4'h0, 4'h2, 1'b0, 8'hE0, 1'b1, 2'h1, 1'b1, 4'h2, 1'b1);
      run(OP_CLEAR_MEMORY_BIT_MEM, 4'hF, 4'h1, 1'b0, 8'hE0, 1'b1, 2'h1, 1'b1, 4'hD);
      run(OP_BAND_C, 4'h2, 4'h1, 1'b0, 8'hE0, 1'b0);
      run(OP_BOR_C, 4'h1, 4'h1, 1'b0, 8'hE0, 1'b1);
      run(OP_CARRY_XOR_BIT_C, 4'h1, 4'h1, 1'b0, 8'hE0, 1'b0);
      run(OP_LDB_MEM_C, 4'hF, 4'h1, 1'b0, 8'hE0, 1'b0, 2'h3, 1'b1, 4'h7);
      run(OP_LDB_C_MEM, 4'h8, 4'h1, 1'b0, 8'hE0, 1'b1, 2'h3);
   endtask

   initial begin
      sys_rst_in   = 1'b1;
      ce_in        = 1'b1;
      start_in     = 1'b0;
      req_in       = '0;
      mem_rdata_in = 4'h0;
      repeat (4) @(posedge clk_in);
      #1;
      check({ready_out, done_out, skip_out, carry_out, ea_out[3:0]}, 8'h80);
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      arith_nibble();
      arith_pair();
      bit_ops();
      freeze();
      summarize();
   end
endmodule // tb

// ### hw/arith_bit_datapath.sv
// Purpose: arithmetic and bit-manipulation execution datapath of a 4-bit cpu
// Assumes: decode hands over one request at a time, memory nibble held stable
// Notes:   skip is signalled to fetch; the skipped instruction is never executed here
`timescale 1ns/10ps
module arith_bit_datapath
   import arith_bit_pkg::*;
#(
   parameter logic [CNT_W-1:0] SKIP_CYCLES = SKIP_CYCLES_DEFAULT
) (
   input  wire logic                clk_in,
   input  wire logic                sys_rst_in,
   input  wire logic                ce_in,
   input  wire logic                start_in,
   input  request_type              req_in,
   input  wire logic [NIBBLE_W-1:0] mem_rdata_in,
   output logic                     ready_out,
   output logic                     done_out,
   output logic                     skip_out,
   output logic                     carry_out,
   output logic      [PAIR_W-1:0]   ea_out,
   output mem_write_type            mem_write_out
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_SKIP = 3'b100
   } state_type;

   state_type          state_reg;
   state_type          state_next;
   request_type        req_reg;
   logic [CNT_W-1:0]   cnt_reg;
   logic [CNT_W-1:0]   cnt_next;
   logic               carry_reg;
   logic               carry_next;
   mem_write_type      mem_write_reg;

   logic               take;
   logic               last_exec;
   request_type        req_view;
   logic [1:0]         rd1_addr;
   logic [PAIR_W-1:0]  ea_rd;
   logic [PAIR_W-1:0]  rr_rd;

   logic [NIBBLE_W-1:0] acc;
   logic [NIBBLE_W-1:0] reg_nib;
   logic                mem_bit;
   logic [CNT_W-1:0]    base_cycles;
   logic                skip_cond;
   logic                carry_wr;
   logic                carry_val;
   logic [1:0]          rf_en;
   logic [1:0]          rf_addr;
   logic [PAIR_W-1:0]   rf_data;
   logic                mem_wr;
   logic [NIBBLE_W-1:0] mem_data;
   logic [NIBBLE_W:0]   sum4;
   logic [PAIR_W:0]     sum8;

   // carry/borrow in bit NIBBLE_W or PAIR_W of the result
   function automatic logic [NIBBLE_W:0] add4(input logic [NIBBLE_W-1:0] a,
                                              input logic [NIBBLE_W-1:0] b,
                                              input logic cin);
      add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction

   function automatic logic [PAIR_W:0] add8(input logic [PAIR_W-1:0] a,
                                            input logic [PAIR_W-1:0] b,
                                            input logic cin);
      add8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
   endfunction

   // borrow is the inverted carry of a + ~b + ~bin
   function automatic logic [NIBBLE_W:0] sub4(input logic [NIBBLE_W-1:0] a,
                                              input logic [NIBBLE_W-1:0] b,
                                              input logic bin);
      logic [NIBBLE_W:0] s;
      s = add4(a, ~b, ~bin);
      sub4 = {~s[NIBBLE_W], s[NIBBLE_W-1:0]};
   endfunction

   function automatic logic [PAIR_W:0] sub8(input logic [PAIR_W-1:0] a,
                                            input logic [PAIR_W-1:0] b,
                                            input logic bin);
      logic [PAIR_W:0] s;
      s = add8(a, ~b, ~bin);
      sub8 = {~s[PAIR_W], s[PAIR_W-1:0]};
   endfunction

   function automatic logic [NIBBLE_W-1:0] put_bit(input logic [NIBBLE_W-1:0] n,
                                                   input logic [1:0] sel,
                                                   input logic v);
      logic [NIBBLE_W-1:0] r;
      r = n;
      r[sel] = v;
      put_bit = r;
   endfunction

   assign take = (state_reg == ST_IDLE) && start_in;
   assign req_view = (state_reg == ST_IDLE) ? req_in : req_reg;

   // nibble operands use the pair that holds the named register
   always_comb begin
      unique case (req_view.op)
         OP_DECREMENT_SKIP_BORROW_R, OP_INCREMENT_SKIP_CARRY_R: rd1_addr = req_view.reg_idx[2:1];
         default:              rd1_addr = req_view.pair_idx;
      endcase
   end

   pair_regfile #(
      .PAIRS (PAIR_COUNT),
      .AW    (PAIR_ADDR_W)
   ) u_regs (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .ce_in        (ce_in),
      .rd0_addr_in  (EA_PAIR),
      .rd0_data_out (ea_rd),
      .rd1_addr_in  (rd1_addr),
      .rd1_data_out (rr_rd),
      .wr_en_in     (rf_en),
      .wr_addr_in   (rf_addr),
      .wr_data_in   (rf_data)
   );

   assign acc     = ea_rd[3:0];
   assign reg_nib = req_reg.reg_idx[0] ? rr_rd[7:4] : rr_rd[3:0];
   assign mem_bit = mem_rdata_in[req_reg.bit_sel];

   always_comb begin
      base_cycles = CYCLES_SHORT;
      skip_cond   = 1'b0;
      carry_wr    = 1'b0;
      carry_val   = carry_reg;
      rf_en       = EN_NONE;
      rf_addr     = EA_PAIR;
      rf_data     = PAIR_RESET;
      mem_wr      = 1'b0;
      mem_data    = mem_rdata_in;
      sum4        = '0;
      sum8        = '0;
      unique case (req_reg.op)
         OP_ADC_A_MEM, OP_ADS_A_MEM, OP_ADS_A_IMM, OP_SBC_A_MEM, OP_SBS_A_MEM: begin
            if (req_reg.op == OP_ADC_A_MEM) begin
               sum4 = add4(acc, mem_rdata_in, carry_reg);
            end else if (req_reg.op == OP_ADS_A_MEM) begin
               sum4 = add4(acc, mem_rdata_in, 1'b0);
            end else if (req_reg.op == OP_ADS_A_IMM) begin
               sum4 = add4(acc, req_reg.imm_lo, 1'b0);
            end else if (req_reg.op == OP_SBC_A_MEM) begin
               sum4 = sub4(acc, mem_rdata_in, carry_reg);
            end else begin
               sum4 = sub4(acc, mem_rdata_in, 1'b0);
            end
            rf_en   = EN_LOW;
            rf_data = {4'h0, sum4[NIBBLE_W-1:0]};
            if (req_reg.op == OP_ADC_A_MEM || req_reg.op == OP_SBC_A_MEM) begin
               carry_wr  = 1'b1;
               carry_val = sum4[NIBBLE_W];
            end else begin
               skip_cond = sum4[NIBBLE_W];
            end
         end
         OP_ADC_EA_RR, OP_ADC_RR_EA, OP_SBC_EA_RR, OP_SBC_RR_EA: begin
            base_cycles = CYCLES_LONG;
            if (req_reg.op == OP_ADC_EA_RR || req_reg.op == OP_ADC_RR_EA) begin
               sum8 = add8(ea_rd, rr_rd, carry_reg);
            end else if (req_reg.op == OP_SBC_EA_RR) begin
               sum8 = sub8(ea_rd, rr_rd, carry_reg);
            end else begin
               sum8 = sub8(rr_rd, ea_rd, carry_reg);
            end
            rf_en     = EN_BOTH;
            rf_addr   = (req_reg.op == OP_ADC_RR_EA || req_reg.op == OP_SBC_RR_EA)
                        ? req_reg.pair_idx : EA_PAIR;
            rf_data   = sum8[PAIR_W-1:0];
            carry_wr  = 1'b1;
            carry_val = sum8[PAIR_W];
         end
         OP_ADS_EA_IMM, OP_ADS_EA_RR, OP_ADS_RR_EA, OP_SBS_EA_RR, OP_SBS_RR_EA: begin
            base_cycles = CYCLES_LONG;
            if (req_reg.op == OP_ADS_EA_IMM) begin
               sum8 = add8(ea_rd, {req_reg.imm_hi, req_reg.imm_lo}, 1'b0);
            end else if (req_reg.op == OP_ADS_EA_RR || req_reg.op == OP_ADS_RR_EA) begin
               sum8 = add8(ea_rd, rr_rd, 1'b0);
            end else if (req_reg.op == OP_SBS_EA_RR) begin
               sum8 = sub8(ea_rd, rr_rd, 1'b0);
            end else begin
               sum8 = sub8(rr_rd, ea_rd, 1'b0);
            end
            rf_en     = EN_BOTH;
            rf_addr   = (req_reg.op == OP_ADS_RR_EA || req_reg.op == OP_SBS_RR_EA)
                        ? req_reg.pair_idx : EA_PAIR;
            rf_data   = sum8[PAIR_W-1:0];
            skip_cond = sum8[PAIR_W];
         end
         OP_DECREMENT_SKIP_BORROW_R, OP_INCREMENT_SKIP_CARRY_R: begin
            if (req_reg.op == OP_DECREMENT_SKIP_BORROW_R) begin
               sum4 = sub4(reg_nib, NIBBLE_ONE, 1'b0);
            end else begin
               sum4 = add4(reg_nib, NIBBLE_ONE, 1'b0);
            end
            rf_en     = req_reg.reg_idx[0] ? EN_HIGH : EN_LOW;
            rf_addr   = req_reg.reg_idx[2:1];
            rf_data   = {sum4[NIBBLE_W-1:0], sum4[NIBBLE_W-1:0]};
            skip_cond = sum4[NIBBLE_W];
         end
         OP_DECREMENT_SKIP_BORROW_RR, OP_INCREMENT_SKIP_CARRY_RR: begin
            if (req_reg.op == OP_DECREMENT_SKIP_BORROW_RR) begin
               base_cycles = CYCLES_LONG;
               sum8 = sub8(rr_rd, PAIR_ONE, 1'b0);
            end else begin
               sum8 = add8(rr_rd, PAIR_ONE, 1'b0);
            end
            rf_en     = EN_BOTH;
            rf_addr   = req_reg.pair_idx;
            rf_data   = sum8[PAIR_W-1:0];
            skip_cond = sum8[PAIR_W];
         end
         OP_INCREMENT_SKIP_CARRY_MEM_DA, OP_INCREMENT_SKIP_CARRY_MEM_HL: begin
            base_cycles = CYCLES_LONG;
            sum4        = add4(mem_rdata_in, NIBBLE_ONE, 1'b0);
            mem_wr      = 1'b1;
            mem_data    = sum4[NIBBLE_W-1:0];
            skip_cond   = sum4[NIBBLE_W];
         end
         OP_TEST_BIT_SKIP_SET_C: begin
            skip_cond = carry_reg;
         end
         default: begin
            // bit group: direct addressing takes the long form
            base_cycles = req_reg.direct_form ? CYCLES_LONG : CYCLES_SHORT;
            unique case (req_reg.op)
               OP_TEST_BIT_SKIP_SET_MEM: skip_cond = mem_bit;
               OP_TEST_BIT_SKIP_ZERO_MEM: skip_cond = ~mem_bit;
               OP_TEST_CLEAR_BIT_SKIP_MEM: begin
                  skip_cond = mem_bit;
                  mem_wr    = mem_bit;
                  mem_data  = put_bit(mem_rdata_in, req_reg.bit_sel, 1'b0);
               end
               OP_BITS_MEM: begin
                  mem_wr   = 1'b1;
                  mem_data = put_bit(mem_rdata_in, req_reg.bit_sel, 1'b1);
               end
               OP_CLEAR_MEMORY_BIT_MEM: begin
                  mem_wr   = 1'b1;
                  mem_data = put_bit(mem_rdata_in, req_reg.bit_sel, 1'b0);
               end
               OP_BAND_C: begin
                  carry_wr  = 1'b1;
                  carry_val = carry_reg & mem_bit;
               end
               OP_BOR_C: begin
                  carry_wr  = 1'b1;
                  carry_val = carry_reg | mem_bit;
               end
               OP_CARRY_XOR_BIT_C: begin
                  carry_wr  = 1'b1;
                  carry_val = carry_reg ^ mem_bit;
               end
               OP_LDB_MEM_C: begin
                  mem_wr   = 1'b1;
                  mem_data = put_bit(mem_rdata_in, req_reg.bit_sel, carry_reg);
               end
               OP_LDB_C_MEM: begin
                  carry_wr  = 1'b1;
                  carry_val = mem_bit;
               end
               default: begin
                  // unknown codes act as a one-cycle no-op
                  base_cycles = CYCLES_SHORT;
               end
            endcase
         end
      endcase
      // results only commit on the final execute cycle
      if (!(state_reg == ST_EXEC && cnt_reg == base_cycles)) begin
         rf_en    = EN_NONE;
         mem_wr   = 1'b0;
         carry_wr = 1'b0;
      end
   end

   assign last_exec = (state_reg == ST_EXEC) && (cnt_reg == base_cycles);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (start_in) begin
               state_next = ST_EXEC;
               cnt_next   = CYCLES_SHORT;
            end
         end
         ST_EXEC: begin
            if (cnt_reg == base_cycles) begin
               if (skip_cond) begin
                  state_next = ST_SKIP;
                  cnt_next   = CYCLES_SHORT;
               end else begin
                  state_next = ST_IDLE;
               end
            end else begin
               cnt_next = cnt_reg + CYCLES_SHORT;
            end
         end
         ST_SKIP: begin
            if (cnt_reg == SKIP_CYCLES) begin
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg + CYCLES_SHORT;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= CYCLES_SHORT;
      end else if (ce_in) begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         req_reg <= '{op: OP_NONE, default: '0};
      end else if (ce_in && take) begin
         req_reg <= req_in;
      end
   end

   assign carry_next = carry_wr ? carry_val : carry_reg;

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         carry_reg <= CARRY_RESET;
      end else if (ce_in) begin
         carry_reg <= carry_next;
      end
   end

   // memory write leaves through a flop, so it shows one cycle after commit
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mem_write_reg <= '0;
      end else if (ce_in) begin
         mem_write_reg.wr   <= mem_wr;
         mem_write_reg.data <= mem_data;
      end
   end

   assign ready_out     = (state_reg == ST_IDLE);
   assign done_out      = (last_exec && !skip_cond) ||
                          (state_reg == ST_SKIP && cnt_reg == SKIP_CYCLES);
   assign skip_out      = (state_reg == ST_SKIP);
   assign carry_out     = carry_reg;
   assign ea_out        = ea_rd;
   assign mem_write_out = mem_write_reg;

endmodule // arith_bit_datapath

// ### hw/arith_bit_pkg.sv
// Purpose: shared types and constants for the arithmetic and bit datapath
// Assumes: 4-bit nibbles, register pairs built from two nibbles
// Notes:   op codes are local to this datapath, not instruction encodings
package arith_bit_pkg;

   localparam int NIBBLE_W = 4;
   localparam int PAIR_W = 8;
   localparam int PAIR_COUNT = 4;
   localparam int PAIR_ADDR_W = 2;
   localparam int CNT_W = 4;

   // the extended accumulator pair lives at pair 0: accumulator low, extension high
   localparam logic [1:0] EA_PAIR = 2'h0;
   localparam logic [1:0] EN_LOW = 2'h1;
   localparam logic [1:0] EN_HIGH = 2'h2;
   localparam logic [1:0] EN_BOTH = 2'h3;
   localparam logic [1:0] EN_NONE = 2'h0;

   localparam logic [CNT_W-1:0] CYCLES_SHORT = 4'h1;
   localparam logic [CNT_W-1:0] CYCLES_LONG = 4'h2;
   localparam logic [CNT_W-1:0] SKIP_CYCLES_DEFAULT = 4'h1;

   localparam logic CARRY_RESET = 1'b0;
   localparam logic [PAIR_W-1:0] PAIR_RESET = 8'h00;
   localparam logic [NIBBLE_W-1:0] NIBBLE_ONE = 4'h1;
   localparam logic [PAIR_W-1:0] PAIR_ONE = 8'h01;

   typedef enum logic [4:0] {
      OP_ADC_A_MEM   = 5'h00, OP_ADC_EA_RR   = 5'h01, OP_ADC_RR_EA   = 5'h02,
      OP_ADS_A_IMM   = 5'h03, OP_ADS_EA_IMM  = 5'h04, OP_ADS_A_MEM   = 5'h05,
      OP_ADS_EA_RR   = 5'h06, OP_ADS_RR_EA   = 5'h07, OP_SBC_A_MEM   = 5'h08,
      OP_SBC_EA_RR   = 5'h09, OP_SBC_RR_EA   = 5'h0A, OP_SBS_A_MEM   = 5'h0B,
      OP_SBS_EA_RR   = 5'h0C, OP_SBS_RR_EA   = 5'h0D, OP_DECREMENT_SKIP_BORROW_R      = 5'h0E,
      OP_DECREMENT_SKIP_BORROW_RR     = 5'h0F, OP_INCREMENT_SKIP_CARRY_R      = 5'h10, OP_INCREMENT_SKIP_CARRY_MEM_DA = 5'h11,
      OP_INCREMENT_SKIP_CARRY_MEM_HL = 5'h12, OP_INCREMENT_SKIP_CARRY_RR     = 5'h13, OP_TEST_BIT_SKIP_SET_C      = 5'h14,
      OP_TEST_BIT_SKIP_SET_MEM    = 5'h15, OP_TEST_BIT_SKIP_ZERO_MEM    = 5'h16, OP_TEST_CLEAR_BIT_SKIP_MEM   = 5'h17,
      OP_BITS_MEM    = 5'h18, OP_CLEAR_MEMORY_BIT_MEM    = 5'h19, OP_BAND_C      = 5'h1A,
      OP_BOR_C       = 5'h1B, OP_CARRY_XOR_BIT_C      = 5'h1C, OP_LDB_MEM_C   = 5'h1D,
      OP_LDB_C_MEM   = 5'h1E, OP_NONE        = 5'h1F
   } op_type;

   typedef struct packed {
      op_type              op;
      logic [NIBBLE_W-1:0] imm_lo;
      logic [NIBBLE_W-1:0] imm_hi;
      logic [2:0]          reg_idx;
      logic [1:0]          pair_idx;
      logic [1:0]          bit_sel;
      logic                direct_form;
   } request_type;

   typedef struct packed {
      logic                wr;
      logic [NIBBLE_W-1:0] data;
   } mem_write_type;

endpackage

// ### hw/pair_regfile.sv
// Purpose: register pairs of the datapath with registered read ports
// Assumes: one write port with nibble enables, two pair-wide read ports
// Notes:   read data lag their address by one clock
`timescale 1ns/10ps
module pair_regfile
   import arith_bit_pkg::*;
#(
   parameter int PAIRS = PAIR_COUNT,
   parameter int AW    = PAIR_ADDR_W
) (
   input  wire logic              clk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              ce_in,
   input  wire logic [AW-1:0]     rd0_addr_in,
   output logic      [PAIR_W-1:0] rd0_data_out,
   input  wire logic [AW-1:0]     rd1_addr_in,
   output logic      [PAIR_W-1:0] rd1_data_out,
   input  wire logic [1:0]        wr_en_in,
   input  wire logic [AW-1:0]     wr_addr_in,
   input  wire logic [PAIR_W-1:0] wr_data_in
);

   logic [PAIR_W-1:0] store_reg [PAIRS];

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < PAIRS; i++) begin
            store_reg[i] <= PAIR_RESET;
         end
      end else if (ce_in) begin
         if (wr_en_in[0]) begin
            store_reg[wr_addr_in][3:0] <= wr_data_in[3:0];
         end
         if (wr_en_in[1]) begin
            store_reg[wr_addr_in][7:4] <= wr_data_in[7:4];
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd0_data_out <= PAIR_RESET;
         rd1_data_out <= PAIR_RESET;
      end else if (ce_in) begin
         rd0_data_out <= store_reg[rd0_addr_in];
         rd1_data_out <= store_reg[rd1_addr_in];
      end
   end

endmodule // pair_regfile
